// *** sdt_pkg.sv ***
// ****************************************************************
// Shared constants and types of the display timing generator.
// ****************************************************************
package sdt_pkg;

   // Width of the horizontal and vertical counter fields.
   localparam int CW = 12;
   // Width of the vertical line counter, wide enough for three fields.
   localparam int LW = CW + 2;
   // Width of an edge offset, counted in half base-clock steps.
   localparam int OFF_W = 8;
   // Depth of the edge history, one more than the largest whole step.
   localparam int HIST_D = (1 << (OFF_W - 1)) + 1;
   // Number of offset-shifted control outputs.
   localparam int NSIG = 3;
   localparam int SIG_HS = 0;
   localparam int SIG_VS = 1;
   localparam int SIG_DV = 2;
   // Fraction bits of the pixel clock divider, one sixteenth each.
   localparam int FRAC_W = 4;
   localparam logic [FRAC_W-1:0] FRAC_ZERO = 4'h0;

   // Register byte addresses.
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PDIV = 8'h04;
   localparam logic [7:0] A_RATIO = 8'h08;
   localparam logic [7:0] A_HLINE = 8'h0c;
   localparam logic [7:0] A_HACT = 8'h10;
   localparam logic [7:0] A_VSYNC = 8'h14;
   localparam logic [7:0] A_VBLANK = 8'h18;
   localparam logic [7:0] A_VACT = 8'h1c;
   localparam logic [7:0] A_OFFS = 8'h20;
   localparam logic [7:0] A_STAT = 8'h24;

   // Reset values: divider of 2.0 base clocks and a ratio of one.
   localparam logic [15:0] PDIV_RST = 16'h0020;
   localparam logic [7:0] RATIO_RST = 8'h01;

   // Control register layout.
   typedef struct packed {
      logic [26:0] rsv;
      logic dv_low;
      logic vs_low;
      logic hs_low;
      logic pclk_inv;
      logic enable;
   } sdt_ctrl_t;

   // Two counter fields in one word.
   typedef struct packed {
      logic [3:0] rsv_hi;
      logic [CW-1:0] hi;
      logic [3:0] rsv_lo;
      logic [CW-1:0] lo;
   } sdt_pair_t;

   // Edge offsets in half base-clock steps.
   typedef struct packed {
      logic [7:0] rsv;
      logic [OFF_W-1:0] dv;
      logic [OFF_W-1:0] vs;
      logic [OFF_W-1:0] hs;
   } sdt_offs_t;

   // Status word.
   typedef struct packed {
      logic [13:0] rsv_hi;
      logic in_frame;
      logic underrun;
      logic [1:0] rsv_lo;
      logic [LW-1:0] line;
   } sdt_stat_t;

   // One pixel, 24-bit colour.
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } sdt_pixel_t;

   // Panel pins, each as {first half, second half} of a base clock.
   typedef struct packed {
      logic [1:0] pixel_clock_out;
      logic [1:0] line_sync_pin;
      logic [1:0] frame_sync_pin;
      logic [1:0] tearing_control_pin;
      logic [1:0] data_valid_strobe;
   } sdt_pins_t;

endpackage : sdt_pkg

// *** sdt_skid_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-entry buffer with valid and ready on both sides.
// ****************************************************************
module sdt_skid_buf #(
   parameter int W = 24
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   logic [W-1:0] mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   // Full and empty follow the entry count directly.
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointers and count move with each accepted word.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end
      else
      begin
         wr_ptr <= wr_ptr ^ push;
         rd_ptr <= rd_ptr ^ pop;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   // Storage takes the word on an accepted push.
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule : sdt_skid_buf
`default_nettype wire

// *** sdt_timing_gen.sv ***
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Synchronous display timing generator.
// ****************************************************************
// Summary of operation
// - Frame sync edges follow their counter start point by a half-step offset.
// - Line sync edges follow their counter start point by a half-step offset.
// - The data valid strobe follows the data's start point by a half-step offset.
// - The pixel clock period is a divider count in sixteenths of a base clock.
// - The average period is the base period times divider over the ratio divisor.
// - Frame sync width and position and blanking before and after are software set.
// - Pixel clock can be inverted and line sync, frame sync and the data valid strobe can be active low.
// - Pixel clock, line and frame sync and one tearing pin have their own pins.
// - Line, frame and strobe edges land to half a base clock, tearing and data bus edges to a whole one.
// - Each counter fixes offset, period and rise and fall of its output.
// - Line sync pulses are spaced exactly one line length apart.
module sdt_timing_gen (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   // Pixel stream in.
   input wire logic pix_valid,
   output logic pix_ready,
   input wire sdt_pkg::sdt_pixel_t pix_data,
   // Panel side.
   output sdt_pkg::sdt_pins_t panel_pins,
   output logic [23:0] panel_data
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   sdt_pkg::sdt_ctrl_t ctrl;
   logic [15:0] pixel_clock_divider;
   logic [7:0] clock_ratio_divisor;
   sdt_pkg::sdt_pair_t hline;
   sdt_pkg::sdt_pair_t hact;
   sdt_pkg::sdt_pair_t vsync;
   sdt_pkg::sdt_pair_t vblank;
   sdt_pkg::sdt_pair_t vact;
   sdt_pkg::sdt_offs_t offs;
   logic underrun;
   sdt_pkg::sdt_stat_t stat;
   logic [31:0] rd_mux;

   // Address decode of writes.
   wire wr_ctrl = reg_we && (reg_addr == sdt_pkg::A_CTRL);
   wire wr_pdiv = reg_we && (reg_addr == sdt_pkg::A_PDIV);
   wire wr_ratio = reg_we && (reg_addr == sdt_pkg::A_RATIO);
   wire wr_hline = reg_we && (reg_addr == sdt_pkg::A_HLINE);
   wire wr_hact = reg_we && (reg_addr == sdt_pkg::A_HACT);
   wire wr_vsync = reg_we && (reg_addr == sdt_pkg::A_VSYNC);
   wire wr_vblank = reg_we && (reg_addr == sdt_pkg::A_VBLANK);
   wire wr_vact = reg_we && (reg_addr == sdt_pkg::A_VACT);
   wire wr_offs = reg_we && (reg_addr == sdt_pkg::A_OFFS);
   wire wr_stat = reg_we && (reg_addr == sdt_pkg::A_STAT);
   wire sdt_pkg::sdt_stat_t wstat = reg_wdata;
   wire clr_underrun = wr_stat && wstat.underrun;

   // Software-set timing parameters; reserved bits stay zero.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         ctrl <= '0;
         pixel_clock_divider <= sdt_pkg::PDIV_RST;
         clock_ratio_divisor <= sdt_pkg::RATIO_RST;
         hline <= '0;
         hact <= '0;
         vsync <= '0;
         vblank <= '0;
         vact <= '0;
         offs <= '0;
      end
      else
      begin
         if (wr_ctrl) ctrl <= '{rsv: '0, dv_low: reg_wdata[4],
            vs_low: reg_wdata[3], hs_low: reg_wdata[2],
            pclk_inv: reg_wdata[1], enable: reg_wdata[0]};
         if (wr_pdiv) pixel_clock_divider <= reg_wdata[15:0];
         if (wr_ratio) clock_ratio_divisor <= reg_wdata[7:0];
         if (wr_hline) hline <= reg_wdata & 32'h0fff0fff;
         if (wr_hact) hact <= reg_wdata & 32'h0fff0fff;
         if (wr_vsync) vsync <= reg_wdata & 32'h0fff0fff;
         if (wr_vblank) vblank <= reg_wdata & 32'h0fff0fff;
         if (wr_vact) vact <= reg_wdata & 32'h0fff0fff;
         if (wr_offs) offs <= reg_wdata & 32'h00ffffff;
      end
   end

   // Read selection; unmapped addresses read as zero.
   always_comb
   begin
      case (reg_addr)
         sdt_pkg::A_CTRL: rd_mux = ctrl;
         sdt_pkg::A_PDIV: rd_mux = {16'h0000, pixel_clock_divider};
         sdt_pkg::A_RATIO: rd_mux = {24'h000000, clock_ratio_divisor};
         sdt_pkg::A_HLINE: rd_mux = hline;
         sdt_pkg::A_HACT: rd_mux = hact;
         sdt_pkg::A_VSYNC: rd_mux = vsync;
         sdt_pkg::A_VBLANK: rd_mux = vblank;
         sdt_pkg::A_VACT: rd_mux = vact;
         sdt_pkg::A_OFFS: rd_mux = offs;
         sdt_pkg::A_STAT: rd_mux = stat;
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         reg_rdata <= 32'h00000000;
      end
      else
      begin
         reg_rdata <= reg_re ? rd_mux : 32'h00000000;
      end
   end

   // ****************************************************************
   // Fractional pixel clock divider
   // ****************************************************************
   logic [16:0] acc;
   logic pclk_level;
   wire [16:0] div_w = {1'b0, pixel_clock_divider};
   wire [16:0] step = {5'h00, clock_ratio_divisor, sdt_pkg::FRAC_ZERO};
   wire [16:0] sum = acc + step;
   wire run = ctrl.enable && (pixel_clock_divider != 16'h0000);
   // One pixel per wrap of the accumulator in sixteenths.
   wire pix_tick = run && (sum >= div_w);
   wire [16:0] next_acc = pix_tick ? sum - div_w : sum;

   // The accumulator gains ratio*16 each base clock and wraps at the
   // divider, so a pixel lasts divider/16/ratio base clocks on average.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || !run)
      begin
         acc <= '0;
         pclk_level <= 1'b0;
      end
      else
      begin
         acc <= next_acc;
         pclk_level <= (next_acc < (div_w >> 1));
      end
   end

   // ****************************************************************
   // Line and frame counters
   // ****************************************************************
   logic [sdt_pkg::CW-1:0] hcount;
   logic [sdt_pkg::LW-1:0] line;
   wire [sdt_pkg::CW:0] hcount_p1 = {1'b0, hcount} + 13'h0001;
   wire h_end = hcount_p1 >= {1'b0, hline.lo};
   wire [sdt_pkg::LW-1:0] vtotal = {2'b00, vblank.lo} +
      {2'b00, vact.lo} + {2'b00, vblank.hi};
   wire [sdt_pkg::LW-1:0] line_p1 = line + 14'h0001;
   wire v_end = line_p1 >= vtotal;
   // Horizontal windows from the line start point.
   wire [sdt_pkg::CW:0] ha_end = {1'b0, hact.lo} + {1'b0, hact.hi};
   wire h_active = (hcount >= hact.lo) && ({1'b0, hcount} < ha_end);
   wire hs_win = hcount < hline.hi;
   // Vertical windows from the frame start point.
   wire [sdt_pkg::LW-1:0] vs_beg = {2'b00, vsync.lo};
   wire [sdt_pkg::LW-1:0] vs_end = vs_beg + {2'b00, vsync.hi};
   wire vs_win = (line >= vs_beg) && (line < vs_end);
   wire [sdt_pkg::LW-1:0] va_beg = {2'b00, vblank.lo};
   wire [sdt_pkg::LW-1:0] va_end = va_beg + {2'b00, vact.lo};
   wire v_active = (line >= va_beg) && (line < va_end);
   wire te_win = line == {2'b00, vact.hi};
   wire act = h_active && v_active;

   // Counters advance on each pixel; the line length sets the period.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || !ctrl.enable)
      begin
         hcount <= '0;
         line <= '0;
      end
      else if (pix_tick)
      begin
         hcount <= h_end ? '0 : hcount_p1[sdt_pkg::CW-1:0];
         if (h_end)
         begin
            line <= v_end ? '0 : line_p1;
         end
      end
   end

   // ****************************************************************
   // Pixel buffer and data bus
   // ****************************************************************
   sdt_pkg::sdt_pixel_t buf_data;
   sdt_pkg::sdt_pixel_t data_q;
   logic buf_valid;
   wire pop = pix_tick && act && buf_valid;
   wire starve = pix_tick && act && !buf_valid;

   // Stalls of the panel side hold words here and push back upstream.
   sdt_skid_buf #(
      .W(24)
   ) u_buf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(pix_valid),
      .in_ready(pix_ready),
      .in_data(pix_data),
      .out_valid(buf_valid),
      .out_ready(pop),
      .out_data(buf_data)
   );

   // Start-point values are caught on the pixel tick.
   logic [sdt_pkg::NSIG-1:0] raw_q;
   logic te_q;
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || !ctrl.enable)
      begin
         raw_q <= '0;
         te_q <= 1'b0;
         data_q <= '0;
      end
      else if (pix_tick)
      begin
         raw_q[sdt_pkg::SIG_HS] <= hs_win;
         raw_q[sdt_pkg::SIG_VS] <= vs_win;
         raw_q[sdt_pkg::SIG_DV] <= act;
         te_q <= te_win;
         if (pop)
         begin
            data_q <= buf_data;
         end
      end
   end

   // The data bus moves on whole base clocks only.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         panel_data <= 24'h000000;
      end
      else
      begin
         panel_data <= {data_q.red, data_q.green, data_q.blue};
      end
   end

   // A pixel slot that finds the buffer empty is latched for software.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         underrun <= 1'b0;
      end
      else
      begin
         underrun <= starve || (underrun && !clr_underrun);
      end
   end

   assign stat = '{rsv_hi: '0, in_frame: v_active, underrun: underrun,
      rsv_lo: '0, line: line};

   // ****************************************************************
   // Half-step edge placement
   // ****************************************************************
   logic [sdt_pkg::HIST_D-2:0] hist [sdt_pkg::NSIG];
   logic [sdt_pkg::NSIG-1:0] first_half;
   logic [sdt_pkg::NSIG-1:0] second_half;
   wire [sdt_pkg::OFF_W-1:0] off_of [sdt_pkg::NSIG];
   wire [sdt_pkg::NSIG-1:0] low_of = {ctrl.dv_low, ctrl.vs_low,
      ctrl.hs_low};
   assign off_of[sdt_pkg::SIG_HS] = offs.hs;
   assign off_of[sdt_pkg::SIG_VS] = offs.vs;
   assign off_of[sdt_pkg::SIG_DV] = offs.dv;

   // An offset of 2m+1 half steps shows the older value in the first
   // half and the newer in the second, so edges land mid-clock.
   for (genvar i = 0; i < sdt_pkg::NSIG; i++)
   begin : g_edge
      wire [sdt_pkg::HIST_D-1:0] taps = {hist[i], raw_q[i]};
      wire [sdt_pkg::OFF_W-1:0] m = off_of[i] >> 1;
      wire [sdt_pkg::OFF_W-1:0] m1 = m + 8'h01;
      always_ff @(posedge clk_sys)
      begin
         if (!rst_n)
         begin
            hist[i] <= '0;
         end
         else
         begin
            hist[i] <= taps[sdt_pkg::HIST_D-2:0];
         end
      end
      assign second_half[i] = taps[m] ^ low_of[i];
      assign first_half[i] = (off_of[i][0] ? taps[m1] : taps[m]) ^
         low_of[i];
   end

   // Pins come straight from flip-flops.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         panel_pins <= '0;
      end
      else
      begin
         panel_pins.pixel_clock_out <= {2{pclk_level ^ ctrl.pclk_inv}};
         panel_pins.line_sync_pin <= {first_half[sdt_pkg::SIG_HS],
            second_half[sdt_pkg::SIG_HS]};
         panel_pins.frame_sync_pin <= {first_half[sdt_pkg::SIG_VS],
            second_half[sdt_pkg::SIG_VS]};
         panel_pins.data_valid_strobe <= {first_half[sdt_pkg::SIG_DV],
            second_half[sdt_pkg::SIG_DV]};
         panel_pins.tearing_control_pin <= {2{te_q}};
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // The accumulator stays below a steady divider.
   accum_bound_a:
   assert property (run && $stable(pixel_clock_divider)
      |=> acc < div_w)
   else $error("Pixel accumulator passed the divider.");

   // Ratio 1 with divider 2.0 gives a pixel every second clock.
   clock_ratio_a:
   assert property (run && pixel_clock_divider == sdt_pkg::PDIV_RST &&
      clock_ratio_divisor == sdt_pkg::RATIO_RST && pix_tick &&
      $stable(ctrl) && $stable(pixel_clock_divider)
      && $stable(clock_ratio_divisor)
      ##1 ($stable(ctrl) && $stable(pixel_clock_divider)
      && $stable(clock_ratio_divisor)) [*2]
      |-> pix_tick && !$past(pix_tick))
   else $error("Pixel period does not match divider over ratio.");

   // The last pixel of a line wraps the column to zero.
   line_wrap_a:
   assert property (ctrl.enable && pix_tick && h_end && !wr_ctrl
      |=> hcount == '0)
   else $error("Line did not wrap at the line length.");

   // A zero offset places both halves on the caught start value.
   hsync_edge_a:
   assert property (offs.hs == '0 && $stable(offs) && $stable(ctrl)
      |=> panel_pins.line_sync_pin ==
         {2{$past(raw_q[sdt_pkg::SIG_HS]) ^ $past(ctrl.hs_low)}})
   else $error("Line sync does not follow its start point.");

   // With an odd offset the first half repeats the last second half.
   half_step_a:
   assert property (offs.vs[0] && $stable(offs) && $stable(ctrl)
      |=> panel_pins.frame_sync_pin[1] ==
         $past(panel_pins.frame_sync_pin[0]))
   else $error("Frame sync edge not moved by half a clock.");

   // Frame sync is caught from the programmed line window.
   vsync_window_a:
   assert property (ctrl.enable && pix_tick
      |=> raw_q[sdt_pkg::SIG_VS] == $past(vs_win))
   else $error("Frame sync start point does not match its window.");

   // The strobe start point is raised after each active pixel tick and holds until the next tick.
   dv_start_a:
   assert property (ctrl.enable && pix_tick && act && !wr_ctrl
      |=> raw_q[sdt_pkg::SIG_DV]
      ##1 (raw_q[sdt_pkg::SIG_DV] || $past(pix_tick)))
   else $error("Data valid start point lost.");

   // Inversion flips the pixel clock pin.
   pclk_polarity_a:
   assert property ($stable(ctrl)
      |=> panel_pins.pixel_clock_out ==
         {2{$past(pclk_level) ^ $past(ctrl.pclk_inv)}})
   else $error("Pixel clock polarity wrong.");

   // Colours land on their byte lanes two clocks after the pop.
   rgb_lanes_a:
   assert property (pop
      |-> ##2 panel_data[7:0] == $past(buf_data.blue, 2) &&
         panel_data[15:8] == $past(buf_data.green, 2) &&
         panel_data[23:16] == $past(buf_data.red, 2))
   else $error("Pixel colours on the wrong data lines.");

   // Tearing pin shows the chosen line.
   te_line_a:
   assert property (ctrl.enable && pix_tick && !wr_ctrl
      |=> ##1 panel_pins.tearing_control_pin == {2{$past(te_win, 2)}})
   else $error("Tearing pin out of step with its line.");

   // The line counter restarts at zero after the last line of the frame.
   frame_count_a:
   assert property (ctrl.enable && pix_tick && h_end && v_end
      && !wr_ctrl |=> line == '0)
   else $error("Frame did not restart after the last line.");

   // Blanking before the active lines holds off the strobe.
   blank_hold_a:
   assert property (line < va_beg |-> !act)
   else $error("Active pixel inside vertical blanking.");

endmodule : sdt_timing_gen
`default_nettype wire

// *** sdt_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Panel model: times the pin edges in half base-clock steps.
// ****************************************************************
module sdt_panel_model (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Panel pins.
   input wire sdt_pkg::sdt_pins_t panel_pins,
   input wire logic [23:0] panel_data,
   // Edge gaps: 0 pixel clock, 1 line, 2 frame, 3 data valid, 4 tearing.
   output int gap [5],
   output int gap2_pclk,
   output logic [4:0] odd,
   output int hs_high,
   output logic [23:0] last_data,
   output logic [23:0] prev_data
);
   logic [1:0] pr [5];
   logic [4:0] pv;
   int now;
   int last [5];
   int t;

   // A rise in the second half of a clock lands on an odd half step.
   always @(posedge clk_sys)
   begin
      pr[0] = panel_pins.pixel_clock_out;
      pr[1] = panel_pins.line_sync_pin;
      pr[2] = panel_pins.frame_sync_pin;
      pr[3] = panel_pins.data_valid_strobe;
      pr[4] = panel_pins.tearing_control_pin;
      if (!rst_n)
      begin
         now = 0;
         pv = 5'h00;
         odd = 5'h00;
         hs_high = 0;
         last_data = 24'h0;
         prev_data = 24'h0;
      end
      else
      begin
         for (int s = 0; s < 5; s++)
         begin
            if ((!pv[s] && pr[s][1]) || (!pr[s][1] && pr[s][0]))
            begin
               odd[s] = !pr[s][1];
               t = now + int'(odd[s]);
               if (s == 0)
                  gap2_pclk = gap[0] + t - last[0];
               gap[s] = t - last[s];
               last[s] = t;
            end
            pv[s] = pr[s][0];
         end
         hs_high += int'(pr[1][1]) + int'(pr[1][0]);
         if (panel_data != last_data && panel_data != 24'h0)
         begin
            prev_data = last_data;
            last_data = panel_data;
         end
         now += 2;
      end
   end
endmodule : sdt_panel_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench of the display timing generator.
// ****************************************************************
module tb;
   logic clk_sys;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_we;
   logic reg_re;
   logic [31:0] reg_rdata;
   logic pix_valid;
   logic pix_ready;
   sdt_pkg::sdt_pixel_t pix_data;
   sdt_pkg::sdt_pins_t panel_pins;
   logic [23:0] panel_data;
   int gap [5];
   int gap2_pclk;
   logic [4:0] odd;
   int hs_high;
   logic [23:0] last_data;
   logic [23:0] prev_data;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int h0;
   logic [31:0] rv;

   sdt_timing_gen dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
      .pix_ready(pix_ready), .pix_data(pix_data),
      .panel_pins(panel_pins), .panel_data(panel_data));
   sdt_panel_model model (.clk_sys(clk_sys), .rst_n(rst_n),
      .panel_pins(panel_pins), .panel_data(panel_data), .gap(gap),
      .gap2_pclk(gap2_pclk), .odd(odd), .hs_high(hs_high),
      .last_data(last_data), .prev_data(prev_data));

   // Base clock of 4 ns.
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic give_verdict;
      if (n_mismatch == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk_sys);
      reg_we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk_sys);
      reg_re <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Waits n edges and lets the edge's updates land.
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : idle

   // Reset values, an unmapped place and the one-cycle read data.
   task automatic t_regs;
      rd(sdt_pkg::A_CTRL, rv);
      chk(rv, 32'h0);
      rd(sdt_pkg::A_PDIV, rv);
      chk(rv, 32'h20);
      rd(sdt_pkg::A_RATIO, rv);
      chk(rv, 32'h1);
      idle(1);
      chk(reg_rdata, 32'h0);
      wr(8'h2c, 32'hffffffff);
      rd(8'h2c, rv);
      chk(rv, 32'h0);
      wr(sdt_pkg::A_CTRL, 32'h2);
      idle(1);
      chk(panel_pins.pixel_clock_out, 2'h3);
      wr(sdt_pkg::A_CTRL, 32'h0);
   endtask : t_regs

   // Two words fill the buffer while the panel side is stopped.
   task automatic t_fill;
      @(posedge clk_sys);
      pix_data <= 24'ha1b2c3;
      pix_valid <= 1'b1;
      @(posedge clk_sys);
      pix_data <= 24'h5d6e7f;
      @(posedge clk_sys);
      pix_valid <= 1'b0;
      #1 chk(pix_ready, 1'b0);
   endtask : t_fill

   // Line of 20, sync of 3, frame of 2+3+1 lines, one tick a clock.
   task automatic t_line;
      wr(sdt_pkg::A_HLINE, 32'h0003_0014);
      wr(sdt_pkg::A_HACT, 32'h0004_0005);
      wr(sdt_pkg::A_VSYNC, 32'h0001_0000);
      wr(sdt_pkg::A_VBLANK, 32'h0001_0002);
      wr(sdt_pkg::A_VACT, 32'h0000_0003);
      wr(sdt_pkg::A_PDIV, 32'h10);
      wr(sdt_pkg::A_CTRL, 32'h1);
      idle(315);
      chk(gap[1], 40);
      chk(gap[2], 240);
      chk(gap[4], 240);
      chk(gap[3], 40);
      chk(prev_data, 24'ha1b2c3);
      chk(last_data, 24'h5d6e7f);
      h0 = hs_high;
      idle(20);
      chk(hs_high - h0, 6);
      wr(sdt_pkg::A_CTRL, 32'h5);
      idle(100);
      h0 = hs_high;
      idle(20);
      chk(hs_high - h0, 34);
      chk(gap[1], 40);
      rd(sdt_pkg::A_STAT, rv);
      chk(rv[16], 1'b1);
   endtask : t_line

   // Offsets of one half step move the line, frame and strobe edges half a clock.
   task automatic t_offs;
      wr(sdt_pkg::A_CTRL, 32'h1);
      idle(60);
      chk(odd[3:1], 3'h0);
      wr(sdt_pkg::A_OFFS, 32'h0001_0101);
      idle(300);
      chk(odd[1], 1'b1);
      chk(odd[2], 1'b1);
      chk(odd[3], 1'b1);
      chk(gap[1], 40);
      wr(sdt_pkg::A_OFFS, 32'h0);
   endtask : t_offs

   // Whole, fractional and ratio-scaled pixel clock periods.
   task automatic t_pclk;
      wr(sdt_pkg::A_PDIV, 32'h20);
      idle(40);
      chk(gap2_pclk, 8);
      wr(sdt_pkg::A_PDIV, 32'h30);
      idle(40);
      chk(gap2_pclk, 12);
      wr(sdt_pkg::A_PDIV, 32'h28);
      idle(40);
      chk(gap2_pclk, 10);
      wr(sdt_pkg::A_RATIO, 32'h2);
      wr(sdt_pkg::A_PDIV, 32'h60);
      idle(40);
      chk(gap2_pclk, 12);
   endtask : t_pclk

   // Cuts a hung run short.
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial
   begin
      rst_n = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      reg_we = 1'b0;
      reg_re = 1'b0;
      pix_valid = 1'b0;
      pix_data = 24'h0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_fill();
      t_line();
      t_offs();
      t_pclk();
      give_verdict();
   end
endmodule : tb
`default_nettype wire
